// ---- hdl/mcr_regs.v ----
// Register block of the memory controller: remap, abort capture and master priorities.
//
// Overview of operation
// - Writing one toggles page-zero remap; zero ignored.
// - Status bit 0 flags undefined-address abort.
// - Status bit 1 flags misaligned-address abort.
// - Bits 9:8 hold aborted access size.
// - Bits 11:10 hold aborted access type.
// - Bits 19:16 name the last aborting master.
// - Bits 27:24 save other masters' aborts since read.
// - Abort address register holds full address.
// - Equal priorities favour the lower master index.
// - Misaligned word or half access aborts, except processor fetches.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_regs (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [3:0]  master_request,
	input  wire [31:0] master_addr,
	input  wire [7:0]  master_size,
	input  wire [7:0]  master_type,
	input  wire        undefined_hit,
	output reg  [3:0]  master_grant,
	output reg         abort_out,
	output reg         remap_active
);
	reg  [31:0] priority_reg;
	reg  [1:0]  abort_cause;
	reg  [1:0]  abort_size_field;
	reg  [1:0]  abort_type_field;
	reg  [3:0]  abort_source;
	reg  [3:0]  saved_abort;
	reg  [31:0] abort_address_field;
	wire [3:0]  grant_now;
	wire        setup;
	wire        wr_en;
	wire        rd_status;
	wire [1:0]  g_size;
	wire [1:0]  g_type;
	wire        misaligned;
	wire        new_abort;
	reg  [31:0] next_prdata;
	reg         next_err;
	reg  [1:0]  sel_size;
	reg  [1:0]  sel_type;
	integer     k;

	mcr_arbiter u_arb (
		.request       (master_request),
		.priority_word (priority_reg),
		.grant         (grant_now)
	);

	// Size and type of the granted master's access.
	always @* begin
		sel_size = `MCR_SIZE_BYTE;
		sel_type = `MCR_TYPE_READ;
		for (k = 0; k < `MCR_NUM_MASTERS; k = k + 1) begin
			if (grant_now[k]) begin
				sel_size = master_size[k*2 +: 2];
				sel_type = master_type[k*2 +: 2];
			end
		end
	end
	assign g_size = sel_size;
	assign g_type = sel_type;

	// Word needs bits 1:0 clear, half-word bit 0 clear; processor fetches skip the check.
	assign misaligned = (|grant_now) &&
		!(grant_now[`MCR_CPU_INDEX] && g_type == `MCR_TYPE_FETCH) &&
		((g_size == `MCR_SIZE_WORD && master_addr[1:0] != 2'b00) ||
		 (g_size == `MCR_SIZE_HALF && master_addr[0]));
	assign new_abort = (|grant_now) && (misaligned || undefined_hit);

	assign setup     = psel && !penable;
	assign wr_en     = psel && penable && pwrite && pready;
	assign rd_status = psel && penable && !pwrite && pready &&
		paddr == `MCR_ADDR_ABORT_STAT;

	// Read data and error are prepared during setup and presented in the access phase.
	always @* begin
		next_prdata = 32'h0;
		next_err    = 1'b0;
		case (paddr)
			`MCR_ADDR_REMAP: next_prdata = 32'h0;
			`MCR_ADDR_ABORT_STAT: begin
				next_prdata[`MCR_BIT_UNDEF]            = abort_cause[0];
				next_prdata[`MCR_BIT_MISAL]            = abort_cause[1];
				next_prdata[`MCR_SIZE_LO +: 2]         = abort_size_field;
				next_prdata[`MCR_TYPE_LO +: 2]         = abort_type_field;
				next_prdata[`MCR_SRC_LO +: 4]          = abort_source;
				next_prdata[`MCR_SAVED_LO +: 4]        = saved_abort;
			end
			`MCR_ADDR_ABORT_ADDR: next_prdata = abort_address_field;
			`MCR_ADDR_PRIORITY:   next_prdata = priority_reg;
			default:              next_err    = 1'b1;
		endcase
	end

	// APB answer: no wait states, pready high in the first access cycle.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata  <= pwrite ? 32'h0 : next_prdata;
				pslverr <= next_err;
			end else begin
				prdata  <= 32'h0;
				pslverr <= 1'b0;
			end
		end
	end

	// Software-written state.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			remap_active <= 1'b0;
			priority_reg <= `MCR_PRIO_RESET;
		end else if (wr_en) begin
			if (paddr == `MCR_ADDR_REMAP && pwdata[`MCR_BIT_REMAP])
				remap_active <= ~remap_active;
			if (paddr == `MCR_ADDR_PRIORITY)
				priority_reg <= pwdata & `MCR_PRIO_MASK;
		end
	end

	// Grant and abort outputs registered.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			master_grant <= 4'h0;
			abort_out    <= 1'b0;
		end else begin
			master_grant <= grant_now;
			abort_out    <= new_abort;
		end
	end

	// Abort capture fields.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			abort_cause         <= 2'b00;
			abort_size_field    <= 2'b00;
			abort_type_field    <= 2'b00;
			abort_source        <= 4'h0;
			abort_address_field <= 32'h0;
		end else if (new_abort) begin
			abort_cause[0]      <= undefined_hit;
			abort_cause[1]      <= misaligned;
			abort_size_field    <= g_size;
			abort_type_field    <= g_type;
			abort_source        <= grant_now;
			abort_address_field <= master_addr;
		end
	end

	// Saved history: previous source moves here when another master takes the source bits.
	genvar m;
	generate
		for (m = 0; m < `MCR_NUM_MASTERS; m = m + 1) begin : g_saved
			always @(posedge core_clk or posedge rst) begin
				if (rst) begin
					saved_abort[m] <= 1'b0;
				end else if (new_abort && abort_source[m] && !grant_now[m]) begin
					saved_abort[m] <= 1'b1;
				end else if (new_abort && grant_now[m]) begin
					saved_abort[m] <= 1'b0;
				end else if (rd_status) begin
					saved_abort[m] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- hdl/mcr_consts.vh ----
// Constants for the memory controller abort, remap and priority register block.
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH
`define MCR_ADDR_REMAP      12'h000
`define MCR_ADDR_ABORT_STAT 12'h004
`define MCR_ADDR_ABORT_ADDR 12'h008
`define MCR_ADDR_PRIORITY   12'h00c
`define MCR_PRIO_RESET      32'h00003210
`define MCR_PRIO_MASK       32'h00007777
`define MCR_BIT_REMAP       0
`define MCR_BIT_UNDEF       0
`define MCR_BIT_MISAL       1
`define MCR_SIZE_LO         8
`define MCR_TYPE_LO         10
`define MCR_SRC_LO          16
`define MCR_SAVED_LO        24
`define MCR_SIZE_BYTE       2'b00
`define MCR_SIZE_HALF       2'b01
`define MCR_SIZE_WORD       2'b10
`define MCR_TYPE_READ       2'b00
`define MCR_TYPE_WRITE      2'b01
`define MCR_TYPE_FETCH      2'b10
`define MCR_NUM_MASTERS     4
`define MCR_PRIO_W          3
`define MCR_PRIO_STRIDE     4
`define MCR_CPU_INDEX       0
`endif

// ---- hdl/mcr_arbiter.v ----
// Priority arbiter for four bus masters with index tie-break.
`timescale 1ns/100ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_arbiter (
	input  wire [3:0]  request,
	input  wire [31:0] priority_word,
	output reg  [3:0]  grant
);
	reg [2:0] best_prio;
	reg       found;
	integer   i;
	always @* begin
		grant     = 4'h0;
		best_prio = 3'h0;
		found     = 1'b0;
		// Strictly greater wins, so an equal later master never displaces an earlier one.
		for (i = 0; i < `MCR_NUM_MASTERS; i = i + 1) begin
			if (request[i] && (!found ||
				priority_word[i*`MCR_PRIO_STRIDE +: `MCR_PRIO_W] > best_prio)) begin
				found     = 1'b1;
				best_prio = priority_word[i*`MCR_PRIO_STRIDE +: `MCR_PRIO_W];
				grant     = 4'h0;
				grant[i]  = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/mcr_master_model.sv ----
// Behavioural model of the four bus masters that feed the abort capture logic.
`timescale 1ns/100ps
`default_nettype none
module mcr_master_model (
	input  wire logic   core_clk,
	output logic [3:0]  master_request,
	output logic [31:0] master_addr,
	output logic [7:0]  master_size,
	output logic [7:0]  master_type,
	output logic        undefined_hit
);
	initial begin
		master_request = 4'h0;
		master_addr = 32'h0;
		master_size = 8'h0;
		master_type = 8'h0;
		undefined_hit = 1'b0;
	end
	// Drives one access for a cycle, then releases the bus with the address inverted.
	task automatic issue(input logic [3:0] r, input logic [31:0] a, input logic [1:0] s,
		input logic [1:0] t, input logic u);
		@(posedge core_clk);
		master_request <= r;
		master_addr <= a;
		master_size <= {4{s}};
		master_type <= {4{t}};
		undefined_hit <= u;
		@(posedge core_clk);
		master_request <= 4'h0;
		master_addr <= ~a;
		undefined_hit <= 1'b0;
		#1;
	endtask
endmodule
`default_nettype wire

// ---- test/mcr_regs_sva.sv ----
// Checker for the remap, arbitration and abort ports of the register block.
`timescale 1ns/100ps
`default_nettype none
module mcr_regs_sva (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic [3:0]  master_request,
	input wire logic [31:0] master_addr,
	input wire logic [7:0]  master_size,
	input wire logic [7:0]  master_type,
	input wire logic        undefined_hit,
	input wire logic [3:0]  master_grant,
	input wire logic        abort_out,
	input wire logic        remap_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_remap_wr;
		pready && psel && pwrite && paddr == 12'h000;
	endsequence
	a_remap_toggle: assert property (s_remap_wr ##0 pwdata[0] |=> remap_active != $past(remap_active))
		else $error("remap did not toggle");
	a_remap_keep: assert property (s_remap_wr ##0 !pwdata[0] |=> $stable(remap_active))
		else $error("remap changed on zero");
	a_remap_wo: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == 32'h0)
		else $error("remap register read back");
	a_grant_one: assert property ($onehot0(master_grant))
		else $error("grant not one hot");
	a_grant_req: assert property (master_grant != 4'h0 |-> |($past(master_request) & master_grant))
		else $error("grant without request");
	a_word_misal: assert property (master_grant == 4'h1 && $past(master_size[1:0]) == 2'b10
		&& $past(master_addr[1:0]) != 2'b00 && $past(master_type[1:0]) != 2'b10 |-> abort_out)
		else $error("misaligned word not aborted");
	a_fetch_free: assert property (master_grant == 4'h1 && $past(master_type[1:0]) == 2'b10
		&& !$past(undefined_hit) |-> !abort_out)
		else $error("fetch aborted");
	a_half_misal: assert property (master_grant == 4'h2 && $past(master_size[3:2]) == 2'b01
		&& $past(master_addr[0]) |-> abort_out)
		else $error("misaligned half not aborted");
	a_undef_abort: assert property (master_grant != 4'h0 && $past(undefined_hit) |-> abort_out)
		else $error("undefined access not aborted");
endmodule
bind mcr_regs mcr_regs_sva chk (.core_clk, .rst, .psel, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .master_request, .master_addr, .master_size, .master_type, .undefined_hit,
	.master_grant, .abort_out, .remap_active);
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the memory controller register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_top;
	logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic        undefined_hit, abort_out, remap_active, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, master_addr, rd;
	logic [7:0]  master_size, master_type;
	logic [3:0]  master_request, master_grant;
	int          fails, cmp_count;
	mcr_regs uut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .master_request, .master_addr, .master_size, .master_type, .undefined_hit,
		.master_grant, .abort_out, .remap_active);
	mcr_master_model bus (.core_clk, .master_request, .master_addr, .master_size,
		.master_type, .undefined_hit);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		#50000;
		fails++;
		conclude();
	end
	initial begin
		fails = 0;
		cmp_count = 0;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		`CHK(remap_active, 1'b0)
		chk_rd(12'h004, 32'h0);
		chk_rd(12'h008, 32'h0);
		chk_rd(12'h00c, 32'h3210);
		chk_rd(12'h010, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, 12'h000, 32'h1);
		`CHK(remap_active, 1'b1)
		apb(1'b1, 12'h000, 32'h0);
		`CHK(remap_active, 1'b1)
		apb(1'b1, 12'h000, 32'h1);
		`CHK(remap_active, 1'b0)
		chk_rd(12'h000, 32'h0);
		apb(1'b1, 12'h00c, 32'hffffffff);
		chk_rd(12'h00c, 32'h7777);
		bus.issue(4'h1, 32'h10000001, 2'b10, 2'b00, 1'b0);
		`CHK(abort_out, 1'b1)
		chk_rd(12'h004, 32'h00010202);
		chk_rd(12'h008, 32'h10000001);
		bus.issue(4'h2, 32'h00400001, 2'b01, 2'b01, 1'b1);
		chk_rd(12'h004, 32'h01020503);
		chk_rd(12'h004, 32'h00020503);
		bus.issue(4'h1, 32'h00000003, 2'b10, 2'b10, 1'b0);
		`CHK(abort_out, 1'b0)
		chk_rd(12'h008, 32'h00400001);
		apb(1'b1, 12'h00c, 32'h7711);
		bus.issue(4'hf, 32'h0, 2'b00, 2'b00, 1'b0);
		`CHK(master_grant, 4'h4)
		apb(1'b1, 12'h00c, 32'h1000);
		bus.issue(4'hf, 32'h0, 2'b00, 2'b00, 1'b0);
		`CHK(master_grant, 4'h8)
		apb(1'b1, 12'h00c, 32'h0);
		bus.issue(4'hf, 32'h0, 2'b00, 2'b00, 1'b0);
		`CHK(master_grant, 4'h1)
		conclude();
	end
endmodule
`default_nettype wire
